//--- rtl/flspm_pkg.sv
// constants for the fuse/lock readback and self-programming sequencer
package flspm_pkg;
    // apb register map
    localparam logic [11:0] CTRL_OFF   = 12'h000;
    localparam logic [11:0] STAT_OFF   = 12'h004;
    // control register bit positions
    localparam int SPMEN_BIT   = 0;
    localparam int ERASE_BIT   = 1;
    localparam int WRITE_BIT   = 2;
    localparam int LOCK_READ_SELECT_BIT  = 3;
    localparam int RWWRE_BIT   = 4;
    localparam int RWWBUSY_BIT = 6;
    localparam int CMD_W       = 5;
    // command codes in the low control field
    localparam logic [4:0] CMD_NONE    = 5'h00;
    localparam logic [4:0] CMD_BUFLOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE   = 5'h03;
    localparam logic [4:0] CMD_WRITE   = 5'h05;
    localparam logic [4:0] CMD_LOCKSET = 5'h09;
    localparam logic [4:0] CMD_RWWRE   = 5'h11;
    // readback z addresses
    localparam logic [16:0] Z_FUSE_LOW  = 17'h00000;
    localparam logic [16:0] Z_LOCK      = 17'h00001;
    localparam logic [16:0] Z_EXT_FUSE  = 17'h00002;
    localparam logic [16:0] Z_FUSE_HIGH = 17'h00003;
    localparam logic [1:0]  LOCK_PAD    = 2'h3;
    // z pointer fields
    localparam int Z_WORD_LSB = 1;
    localparam int Z_WORD_MSB = 7;
    localparam int Z_PAGE_LSB = 8;
    localparam int Z_PAGE_MSB = 16;
    // window lengths in cpu cycles
    localparam logic [2:0] LOAD_WIN  = 3'h3;
    localparam logic [2:0] STORE_WIN = 3'h4;
    // flash operation time, in ms, and rc oscillator ticks
    localparam real FLASH_MIN_MS   = 3.7;
    localparam real FLASH_MAX_MS   = 4.5;
    localparam int  RC_KHZ         = 1000;
    localparam int  FLASH_MIN_TICK = int'($ceil(FLASH_MIN_MS * RC_KHZ));
    localparam int  FLASH_MAX_TICK = int'($floor(FLASH_MAX_MS * RC_KHZ));
    localparam int  TICK_W         = 16;
    // first page of the no-read-while-write section
    localparam logic [8:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 9'h1e0;
    // flash operation kinds
    typedef enum logic [1:0] {
        FLSPM_OP_IDLE  = 2'b00,
        FLSPM_OP_ERASE = 2'b01,
        FLSPM_OP_WRITE = 2'b10,
        FLSPM_OP_LOCK  = 2'b11
    } flspm_op_t;
endpackage

//--- rtl/flspm_optimer.sv
// flash operation duration timer running on rc oscillator ticks
`timescale 1ns/10ps
`default_nettype none
module flspm_optimer
    import flspm_pkg::*;
#(
    parameter int TICKS = flspm_pkg::FLASH_MIN_TICK
) (
    input  wire logic clk,
    input  wire logic por_rst,
    input  wire logic ce,
    input  wire logic start,
    input  wire logic rc_tick,
    output logic      busy,
    output logic      done
);
    logic [TICK_W-1:0] cnt_q, cnt_d;
    logic              busy_q, busy_d;
    logic              done_q, done_d;

    // ***************************************
    // tick counting; only power-on reset stops it
    // ***************************************
    // the first tick may follow start at once, so TICKS+1 ticks span TICKS whole periods
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start && !busy_q) begin
            cnt_d  = '0;
            busy_d = 1'b1;
        end else if (busy_q && rc_tick) begin
            if (cnt_q == TICK_W'(TICKS)) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (por_rst) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
endmodule
`default_nettype wire

//--- rtl/flspm_top.sv
// self-programming controller: fuse/lock readback, command windows, flash timing
`timescale 1ns/10ps
`default_nettype none
module flspm_top #(
    parameter int          OP_TICKS   = flspm_pkg::FLASH_MIN_TICK,
    parameter logic [8:0]  NO_READ_WHILE_WRITE_SECTION_PAGE  = flspm_pkg::NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        por_rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        lpm_req,
    input  wire logic        spm_req,
    input  wire logic [16:0] core_z,
    input  wire logic [7:0]  spm_r0,
    input  wire logic [7:0]  flash_rdata,
    output logic      [7:0]  lpm_rdata,
    output logic             lpm_valid,
    input  wire logic [7:0]  fuse_low,
    input  wire logic [7:0]  fuse_high,
    input  wire logic [7:0]  extended_fuse,
    input  wire logic [5:0]  lock_bits,
    input  wire logic        eeprom_write_busy,
    input  wire logic        rc_tick,
    output logic             flash_start,
    output flspm_pkg::flspm_op_t flash_op,
    output logic      [8:0]  flash_page,
    output logic      [6:0]  flash_word,
    output logic      [7:0]  lock_wr_data,
    output logic             buf_load,
    output logic             buf_clear,
    output logic             rww_busy,
    output logic             rww_read_block,
    output logic             cpu_halt
);
    import flspm_pkg::*;

    // ***************************************
    // state
    // ***************************************
    logic [CMD_W-1:0] cmd_q, cmd_d;
    logic [2:0]       cyc_q, cyc_d;
    flspm_op_t        op_q, op_d;
    logic             rwwb_q, rwwb_d, halt_q, halt_d;
    logic [31:0]      prdata_q, prdata_d;
    logic             pready_q, pready_d, pslverr_q, pslverr_d;
    logic [7:0]       lrd_q, lrd_d;
    logic             lval_q, start_q, start_d, bl_q, bl_d, bc_q, bc_d;
    logic [8:0]       page_q, page_d;
    logic [6:0]       word_q, word_d;
    logic [7:0]       lwd_q, lwd_d;
    logic             op_busy, op_done, armed, rb_hit, spm_hit, ctrl_wr;

    // readback source chosen by the z pointer
    function automatic logic [7:0] pick_fuse(input logic [16:0] z);
        if (z == Z_LOCK) begin
            pick_fuse = {LOCK_PAD, lock_bits};
        end else if (z == Z_FUSE_HIGH) begin
            pick_fuse = fuse_high;
        end else if (z == Z_EXT_FUSE) begin
            pick_fuse = extended_fuse;
        end else begin
            pick_fuse = fuse_low;
        end
    endfunction

    flspm_optimer #(
        .TICKS (OP_TICKS)
    ) u_timer (
        .clk     (clk),
        .por_rst (por_rst),
        .ce      (ce),
        .start   (start_q),
        .rc_tick (rc_tick),
        .busy    (op_busy),
        .done    (op_done)
    );

    // ***************************************
    // window and readback qualification
    // ***************************************
    assign armed   = cmd_q[SPMEN_BIT];
    assign ctrl_wr = psel && penable && pready_q && pwrite && (paddr == CTRL_OFF);
    assign rb_hit  = armed && (cmd_q == CMD_LOCKSET) && lpm_req && (cyc_q < LOAD_WIN)
                     && !eeprom_write_busy && (core_z <= Z_FUSE_HIGH);
    assign spm_hit = armed && spm_req && (cyc_q < STORE_WIN) && !eeprom_write_busy;

    // ***************************************
    // control, command execution and flash operation tracking
    // ***************************************
    always_comb begin
        cmd_d   = cmd_q;
        cyc_d   = (cyc_q < STORE_WIN) ? cyc_q + 3'h1 : cyc_q;
        op_d    = op_q;
        rwwb_d  = rwwb_q;
        halt_d  = halt_q;
        start_d = 1'b0;
        bl_d    = 1'b0;
        bc_d    = 1'b0;
        page_d  = page_q;
        word_d  = word_q;
        lwd_d   = lwd_q;
        if (op_done) begin
            op_d   = FLSPM_OP_IDLE;
            halt_d = 1'b0;
            bc_d   = (op_q == FLSPM_OP_WRITE);
        end
        if (rb_hit) begin
            cmd_d = CMD_NONE;
        end else if (spm_hit) begin
            cmd_d  = CMD_NONE;
            page_d = core_z[Z_PAGE_MSB:Z_PAGE_LSB];
            word_d = core_z[Z_WORD_MSB:Z_WORD_LSB];
            case (cmd_q)
                CMD_BUFLOAD: begin
                    bl_d = 1'b1;
                end
                CMD_ERASE, CMD_WRITE: begin
                    start_d = 1'b1;
                    op_d    = (cmd_q == CMD_ERASE) ? FLSPM_OP_ERASE : FLSPM_OP_WRITE;
                    if (core_z[Z_PAGE_MSB:Z_PAGE_LSB] < NO_READ_WHILE_WRITE_SECTION_PAGE) begin
                        rwwb_d = 1'b1;
                    end else begin
                        halt_d = 1'b1;
                    end
                end
                CMD_LOCKSET: begin
                    start_d = 1'b1;
                    op_d    = FLSPM_OP_LOCK;
                    lwd_d   = spm_r0;
                end
                CMD_RWWRE: begin
                    if (!op_busy) begin
                        rwwb_d = 1'b0;
                        bc_d   = 1'b1;
                    end
                end
                default: begin
                    cmd_d = CMD_NONE;
                end
            endcase
        end else if (armed && (cyc_q == STORE_WIN - 3'h1)) begin
            cmd_d = CMD_NONE;
        end
        // a new command is refused while flash or eeprom is busy
        if (ctrl_wr && !op_busy && (op_q == FLSPM_OP_IDLE) && !eeprom_write_busy) begin
            cmd_d = pwdata[CMD_W-1:0];
            cyc_d = 3'h0;
        end
    end

    // ***************************************
    // apb slave, zero wait state
    // ***************************************
    always_comb begin
        pready_d  = psel && !penable;
        pslverr_d = 1'b0;
        prdata_d  = '0;
        if (psel && !penable) begin
            if (paddr == CTRL_OFF) begin
                prdata_d[CMD_W-1:0]   = cmd_q;
                prdata_d[SPMEN_BIT]   = armed || op_busy;
                prdata_d[RWWBUSY_BIT] = rwwb_q;
            end else if (paddr == STAT_OFF) begin
                prdata_d[1:0] = op_q;
                prdata_d[2]   = halt_q;
                prdata_d[3]   = eeprom_write_busy;
                prdata_d[6:4] = cyc_q;
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    // ***************************************
    // program load answer
    // ***************************************
    always_comb begin
        lrd_d = rb_hit ? pick_fuse(core_z) : flash_rdata;
    end

    // ***************************************
    // registers; flash state except flash_word and buf_load survives sys_rst
    // ***************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_q     <= CMD_NONE;
            cyc_q     <= STORE_WIN;
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            lrd_q     <= '0;
            lval_q    <= 1'b0;
            bl_q      <= 1'b0;
            word_q    <= '0;
        end else if (ce) begin
            cmd_q     <= cmd_d;
            cyc_q     <= cyc_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            lrd_q     <= lrd_d;
            lval_q    <= lpm_req;
            bl_q      <= bl_d;
            word_q    <= word_d;
        end
    end

    always_ff @(posedge clk) begin
        if (por_rst) begin
            op_q    <= FLSPM_OP_IDLE;
            rwwb_q  <= 1'b0;
            halt_q  <= 1'b0;
            start_q <= 1'b0;
            bc_q    <= 1'b0;
            page_q  <= '0;
            lwd_q   <= '0;
        end else if (ce) begin
            op_q    <= op_d;
            rwwb_q  <= rwwb_d;
            halt_q  <= halt_d;
            start_q <= start_d;
            bc_q    <= bc_d;
            page_q  <= page_d;
            lwd_q   <= lwd_d;
        end
    end

    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign lpm_rdata      = lrd_q;
    assign lpm_valid      = lval_q;
    assign flash_start    = start_q;
    assign flash_op       = op_q;
    assign flash_page     = page_q;
    assign flash_word     = word_q;
    assign lock_wr_data   = lwd_q;
    assign buf_load       = bl_q;
    assign buf_clear      = bc_q;
    assign rww_busy       = rwwb_q;
    assign rww_read_block = rwwb_q;
    assign cpu_halt       = halt_q;

    // ***************************************
    // checks
    // ***************************************
    chk_lock_readback: assert property (@(posedge clk) disable iff (sys_rst || por_rst)
        (ce && rb_hit && core_z == Z_LOCK) |=> (lpm_rdata == {LOCK_PAD, $past(lock_bits)}))
        else $error("lock byte readback wrong");
    chk_fuse_low_rd: assert property (@(posedge clk) disable iff (sys_rst || por_rst)
        (ce && rb_hit && core_z == Z_FUSE_LOW) |=> (lpm_rdata == $past(fuse_low)))
        else $error("fuse low readback wrong");
    chk_fuse_high_rd: assert property (@(posedge clk) disable iff (sys_rst || por_rst)
        (ce && rb_hit && core_z == Z_FUSE_HIGH) |=> (lpm_rdata == $past(fuse_high)))
        else $error("fuse high readback wrong");
    chk_ext_fuse_rd: assert property (@(posedge clk) disable iff (sys_rst || por_rst)
        (ce && rb_hit && core_z == Z_EXT_FUSE) |=> (lpm_rdata == $past(extended_fuse)))
        else $error("extended fuse readback wrong");
    chk_window_expiry: assert property (@(posedge clk) disable iff (sys_rst || por_rst)
        (ce && armed && cyc_q == (STORE_WIN - 3'h1) && !spm_req && !ctrl_wr) |=> (cmd_q == CMD_NONE))
        else $error("armed bits not cleared after store window");
    chk_plain_load: assert property (@(posedge clk) disable iff (sys_rst || por_rst)
        (ce && lpm_req && !armed) |=> (lpm_valid && lpm_rdata == $past(flash_rdata)))
        else $error("ordinary load not from program memory");
    chk_eeprom_block: assert property (@(posedge clk) disable iff (sys_rst || por_rst)
        (ce && eeprom_write_busy) |=> (!flash_start && !buf_load))
        else $error("flash action during eeprom write");
    chk_late_store: assert property (@(posedge clk) disable iff (sys_rst || por_rst)
        (ce && spm_req && (!armed || cyc_q >= STORE_WIN)) |=> !flash_start)
        else $error("store outside window took effect");
    chk_rww_blocked: assert property (@(posedge clk) disable iff (sys_rst || por_rst)
        (ce && start_q && op_q != FLSPM_OP_LOCK && !halt_q) |-> rww_read_block)
        else $error("rww readable during erase or write");
    chk_op_survives: assert property (@(posedge clk) disable iff (por_rst)
        (ce && sys_rst && op_q != FLSPM_OP_IDLE && !op_done) |=> (op_q != FLSPM_OP_IDLE))
        else $error("reset aborted flash operation");
endmodule
`default_nettype wire

//--- verif/flspm_core_model.sv
// cpu core model: apb master of the control register, load and store issue
`timescale 1ns/10ps
`default_nettype none
module flspm_core_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             lpm_req,
    output logic             spm_req,
    output logic      [16:0] core_z,
    output logic      [7:0]  spm_r0,
    output logic      [7:0]  flash_rdata,
    input  wire logic [7:0]  lpm_rdata,
    input  wire logic        lpm_valid,
    input  wire logic        buf_load,
    input  wire logic        flash_start,
    input  wire logic        eeprom_write_busy
);
    import flspm_pkg::*;
    logic [31:0] rd;    // last read data
    logic        err;   // last slave error
    logic        got_v; // load answer valid
    logic [7:0]  got_d; // load answer byte
    logic        got_b; // buffer load seen
    logic        got_s; // flash start seen
    // program memory content is a fixed pattern of the z pointer
    assign flash_rdata = core_z[7:0] ^ 8'h5c;
    // idle bus and core at time zero
    initial begin
        {psel, penable, pwrite, lpm_req, spm_req} = 5'h00;
        {paddr, pwdata, core_z, spm_r0} = '0;
    end
    // one apb transfer; entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk); // idle edge, so a following call never drives psel twice at once
    endtask
    // program_load for one cycle, answer taken a cycle later
    task automatic load(input logic [16:0] z);
        lpm_req <= 1'b1;
        core_z  <= z;
        @(posedge clk);
        lpm_req <= 1'b0;
        @(negedge clk);
        got_v = lpm_valid;
        got_d = lpm_rdata;
        @(posedge clk);
    endtask
    // program_store for one cycle, start and buffer pulses taken a cycle later
    task automatic store(input logic [16:0] z, input logic [7:0] r0);
        spm_req <= 1'b1;
        core_z  <= z;
        spm_r0  <= r0;
        @(posedge clk);
        spm_req <= 1'b0;
        @(negedge clk);
        got_b = buf_load;
        got_s = flash_start;
        @(posedge clk);
    endtask
    // timed sequence: wait for idle, write command, store at once
    task automatic do_spm(input logic [4:0] cmd, input logic [16:0] z, input logic [7:0] r0);
        rd = 32'h1;
        while (rd[SPMEN_BIT] !== 1'b0) apb(1'b0, CTRL_OFF, 32'h0);
        while (eeprom_write_busy !== 1'b0) @(posedge clk);
        apb(1'b1, CTRL_OFF, {27'h0, cmd});
        store(z, r0);
    endtask
endmodule
`default_nettype wire

//--- verif/flspm_top_tb_top.sv
// self-checking bench of the self-programming controller
`timescale 1ns/10ps
`default_nettype none
module flspm_top_tb_top;
    import flspm_pkg::*;
    localparam int         OPT = 4; // shortened flash operation, rc ticks
    localparam logic [7:0] FL  = 8'h3a;
    localparam logic [7:0] FH  = 8'hc5;
    localparam logic [7:0] FE  = 8'hf6;
    localparam logic [5:0] LK  = 6'h2d;
    logic        clk, sys_rst, por_rst, rc_tick, eeprom_write_busy;
    logic        ce = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, lpm_req, spm_req, lpm_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [16:0] core_z;
    logic [7:0]  spm_r0, flash_rdata, lpm_rdata, lock_wr_data;
    logic [8:0]  flash_page;
    logic [6:0]  flash_word;
    logic        flash_start, buf_load, buf_clear, rww_busy, rww_read_block, cpu_halt;
    flspm_op_t   flash_op;
    int          mismatches = 0;
    int          compares = 0;
    int          tick_cnt = 0;
    int          clr_cnt = 0;
    flspm_top #(.OP_TICKS(OPT), .NO_READ_WHILE_WRITE_SECTION_PAGE(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)) DUT (
        .clk(clk), .sys_rst(sys_rst), .por_rst(por_rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lpm_req(lpm_req),
        .spm_req(spm_req), .core_z(core_z), .spm_r0(spm_r0), .flash_rdata(flash_rdata),
        .lpm_rdata(lpm_rdata), .lpm_valid(lpm_valid), .fuse_low(FL), .fuse_high(FH),
        .extended_fuse(FE), .lock_bits(LK), .eeprom_write_busy(eeprom_write_busy),
        .rc_tick(rc_tick), .flash_start(flash_start), .flash_op(flash_op),
        .flash_page(flash_page), .flash_word(flash_word), .lock_wr_data(lock_wr_data),
        .buf_load(buf_load), .buf_clear(buf_clear), .rww_busy(rww_busy),
        .rww_read_block(rww_read_block), .cpu_halt(cpu_halt));
    flspm_core_model core (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lpm_req(lpm_req), .spm_req(spm_req), .core_z(core_z), .spm_r0(spm_r0),
        .flash_rdata(flash_rdata), .lpm_rdata(lpm_rdata), .lpm_valid(lpm_valid),
        .buf_load(buf_load), .flash_start(flash_start),
        .eeprom_write_busy(eeprom_write_busy));
    // 250 mhz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // rc oscillator tick, every 8 cycles to keep runs short
    initial begin
        rc_tick = 1'b0;
        forever begin
            repeat (7) @(posedge clk);
            rc_tick <= 1'b1;
            @(posedge clk);
            rc_tick <= 1'b0;
        end
    end
    // count rc ticks seen while an operation runs
    always @(posedge clk) if (rc_tick === 1'b1 && flash_op !== FLSPM_OP_IDLE) tick_cnt++;
    // count page buffer clear pulses, mid-cycle so tasks never race the count
    always @(negedge clk) if (buf_clear === 1'b1) clr_cnt++;
    // ********************************
    // helpers
    // ********************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr_cmd(input logic [4:0] c);
        core.apb(1'b1, CTRL_OFF, {27'h0, c});
    endtask
    task automatic wait_idle;
        int n = 0;
        while (flash_op !== FLSPM_OP_IDLE && n < 500) begin
            n++;
            @(posedge clk);
        end
        chk(n < 500, 1'b1, "operation ends");
    endtask
    // ********************************
    // scenarios
    // ********************************
    task automatic t_regs;
        core.apb(1'b0, CTRL_OFF, 32'h0);
        chk(core.rd, 32'h0, "control reset");
        core.apb(1'b0, STAT_OFF, 32'h0);
        chk(core.rd & 32'h0f, 32'h0, "status reset");
        core.apb(1'b1, 12'h008, 32'hffff_ffff);
        chk(core.err, 1'b1, "unmapped write");
        core.apb(1'b0, 12'h008, 32'h0);
        chk({core.err, core.rd[30:0]}, 32'h8000_0000, "unmapped read");
        $display("test regs done");
    endtask
    task automatic t_readback;
        logic [7:0]  ex [4];
        logic [16:0] zs [4];
        ex = '{FL, {LOCK_PAD, LK}, FE, FH};
        zs = '{Z_FUSE_LOW, Z_LOCK, Z_EXT_FUSE, Z_FUSE_HIGH};
        for (int i = 0; i < 4; i++) begin
            wr_cmd(CMD_LOCKSET);
            core.load(zs[i]);
            chk(core.got_v, 1'b1, "readback valid");
            chk(core.got_d, ex[i], "readback byte");
            core.load(zs[i]);
            chk(core.got_d, zs[i][7:0] ^ 8'h5c, "load after readback");
        end
        $display("test readback done");
    endtask
    task automatic t_windows;
        wr_cmd(CMD_LOCKSET);
        repeat (1) @(posedge clk);
        core.load(Z_FUSE_LOW);
        chk(core.got_d, FL, "load in third cycle");
        wr_cmd(CMD_LOCKSET);
        repeat (2) @(posedge clk);
        core.load(Z_FUSE_LOW);
        chk(core.got_d, 8'h5c, "load in fourth cycle");
        core.apb(1'b0, CTRL_OFF, 32'h0);
        chk(core.rd[SPMEN_BIT], 1'b0, "armed bit cleared");
        wr_cmd(CMD_BUFLOAD);
        repeat (2) @(posedge clk);
        core.store(17'h0, 8'h0);
        chk(core.got_b, 1'b1, "store in fourth cycle");
        wr_cmd(CMD_BUFLOAD);
        repeat (3) @(posedge clk);
        core.store(17'h0, 8'h0);
        chk(core.got_b, 1'b0, "store in fifth cycle");
        wr_cmd(5'h07);
        core.store(17'h0, 8'h0);
        chk({core.got_b, core.got_s}, 2'b00, "unknown command");
        $display("test windows done");
    endtask
    task automatic t_fill;
        for (int i = 0; i < 4; i++) begin
            core.do_spm(CMD_BUFLOAD, 17'(2 * i), 8'h0);
            chk(core.got_b, 1'b1, "page buffer word");
            chk(flash_word, 7'(i), "page buffer word index");
        end
        $display("test fill done");
    endtask
    task automatic t_eeprom;
        wr_cmd(CMD_LOCKSET);
        eeprom_write_busy <= 1'b1;
        core.load(Z_LOCK);
        chk(core.got_d, 8'h01 ^ 8'h5c, "readback blocked");
        core.apb(1'b0, STAT_OFF, 32'h0);
        chk(core.rd[3], 1'b1, "eeprom busy status");
        wr_cmd(CMD_BUFLOAD);
        core.store(17'h0, 8'h0);
        chk(core.got_b, 1'b0, "programming blocked");
        eeprom_write_busy <= 1'b0;
        @(posedge clk);
        $display("test eeprom done");
    endtask
    task automatic t_erase;
        tick_cnt = 0;
        core.do_spm(CMD_ERASE, 17'h00300, 8'h0);
        chk(core.got_s, 1'b1, "erase start");
        chk(flash_op, FLSPM_OP_ERASE, "erase op");
        chk(flash_page, 9'h003, "erase page");
        chk({rww_busy, rww_read_block, cpu_halt}, 3'b110, "rww blocked");
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(flash_op, FLSPM_OP_ERASE, "erase survives reset");
        wait_idle;
        chk(tick_cnt >= OPT + 1 && tick_cnt <= OPT + 2, 1'b1, "erase length");
        chk(rww_busy, 1'b1, "rww busy after erase");
        clr_cnt = 0;
        core.do_spm(CMD_RWWRE, 17'h0, 8'h0);
        chk(rww_busy, 1'b0, "rww reenabled");
        chk(clr_cnt, 1, "buffer cleared by rww reenable");
        $display("test erase done");
    endtask
    task automatic t_write_lock;
        clr_cnt = 0;
        core.do_spm(CMD_WRITE, {NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE, 8'h00}, 8'h0);
        chk(flash_op, FLSPM_OP_WRITE, "write op");
        chk(cpu_halt, 1'b1, "no_read_while_write_section halt");
        core.do_spm(CMD_LOCKSET, Z_LOCK, 8'hc3);
        chk(cpu_halt, 1'b0, "halt released");
        chk(flash_op, FLSPM_OP_LOCK, "lock op");
        chk(lock_wr_data, 8'hc3, "lock data");
        chk(clr_cnt, 1, "buffer cleared after page write");
        wr_cmd(CMD_BUFLOAD);
        core.store(17'h0, 8'h0);
        chk(core.got_b, 1'b0, "command refused while busy");
        wait_idle;
        $display("test write and lock done");
    endtask
    // main sequence
    initial begin
        sys_rst = 1'b1;
        por_rst = 1'b1;
        eeprom_write_busy = 1'b0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_readback;
        t_windows;
        t_fill;
        t_eeprom;
        t_erase;
        t_write_lock;
        complete_run;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        mismatches++;
        complete_run;
    end
endmodule
`default_nettype wire
